// ===== design/frt_pkg.sv
package frt_pkg;

    // clock and timer geometry
    localparam int CLK_PERIOD_NS = 8;
    localparam int TMR_W         = 24;

    // event to output latencies, printed figures in ns
    localparam int T_NOTIFY_TYP_NS = 2000;
    localparam int T_NOTIFY_MAX_NS = 4500;
    localparam int T_OFF_CLA_MAX_NS = 400;
    localparam int T_OFF_CLB_MAX_NS = 400;
    localparam int T_OFF_DESAT_MAX_NS = 430;
    localparam int T_OFF_OC_MAX_NS = 130;

    // supervision intervals in their own units
    localparam int T_VMTO_SHORT_MS = 15;
    localparam int T_VMTO_LONG_MS  = 60;
    localparam int T_GMTO_NS       = 15000;
    localparam int T_LS_NS         = 5000;
    localparam int T_OSM_NS        = 4000;
    localparam int T_DEAD_MIN_NS   = 840;
    localparam int T_DEAD_MAX_NS   = 1200;
    localparam int T_DEAD_STEP_NS  = 200;

    // derived cycle counts: maxima round down, minima round up
    localparam int NOTIFY_CYC      = T_NOTIFY_TYP_NS / CLK_PERIOD_NS;
    localparam int NOTIFY_MAX_CYC  = T_NOTIFY_MAX_NS / CLK_PERIOD_NS;
    localparam int OFF_CLA_MAX_CYC = T_OFF_CLA_MAX_NS / CLK_PERIOD_NS;
    localparam int OFF_CLB_MAX_CYC = T_OFF_CLB_MAX_NS / CLK_PERIOD_NS;
    localparam int OFF_DESAT_MAX_CYC = T_OFF_DESAT_MAX_NS / CLK_PERIOD_NS;
    localparam int OFF_OC_MAX_CYC  = T_OFF_OC_MAX_NS / CLK_PERIOD_NS;
    localparam int VMTO_SHORT_CYC  = T_VMTO_SHORT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int VMTO_LONG_CYC   = T_VMTO_LONG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int GMTO_CYC        = T_GMTO_NS / CLK_PERIOD_NS;
    localparam int LS_CYC          = T_LS_NS / CLK_PERIOD_NS;
    localparam int OSM_CYC         = T_OSM_NS / CLK_PERIOD_NS;
    localparam int DEAD_MIN_CYC    = (T_DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_MAX_CYC    = T_DEAD_MAX_NS / CLK_PERIOD_NS;
    localparam int DEAD_STEP_CYC   = T_DEAD_STEP_NS / CLK_PERIOD_NS;

    // shoot-through delay field
    localparam int          STP_W       = 4;
    localparam logic [3:0]  STP_DEFAULT = 4'h4;

    // positions in the synchronised input vector
    localparam int IN_CLA    = 0;
    localparam int IN_CLB    = 1;
    localparam int IN_DESAT  = 2;
    localparam int IN_DSBLK  = 3;
    localparam int IN_OC     = 4;
    localparam int IN_OCBLK  = 5;
    localparam int IN_OP2    = 6;
    localparam int IN_VER    = 7;
    localparam int IN_VSEL   = 8;
    localparam int IN_GFB    = 9;
    localparam int IN_LIFE   = 10;
    localparam int IN_HARD   = 11;
    localparam int IN_OSMOK  = 12;
    localparam int IN_PWM    = 13;
    localparam int IN_CLR    = 14;
    localparam int IN_STP    = 15;
    localparam int IN_W      = IN_STP + STP_W;

endpackage : frt_pkg

// ===== design/frt_tmr_if.sv
interface frt_tmr_if;
    logic                     start;
    logic [frt_pkg::TMR_W-1:0] load;
    logic                     busy;
    logic                     done;

    modport owner (output start, output load, input busy, input done);
    modport timer (input start, input load, output busy, output done);
endinterface : frt_tmr_if

// ===== design/frt_sync.sv
module frt_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } frt_sync_st_t;

    frt_sync_st_t r;
    frt_sync_st_t r_nxt;

    // two-stage shift, only the second stage is read outside
    always_comb
    begin
        r_nxt    = r;
        r_nxt.s1 = d;
        r_nxt.s2 = r.s1;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            r <= '0;
        else
            r <= r_nxt;
    end

    assign q = r.s2;
endmodule : frt_sync

// ===== design/frt_timer.sv
module frt_timer (
    input  wire logic mclk,
    input  wire logic srst,
    frt_tmr_if.timer  t
);
    typedef struct packed {
        logic [frt_pkg::TMR_W-1:0] cnt;
        logic                      busy;
        logic                      done;
    } frt_timer_st_t;

    frt_timer_st_t r;
    frt_timer_st_t r_nxt;

    // a start always reloads, even while running
    always_comb
    begin
        r_nxt      = r;
        r_nxt.done = 1'b0;
        if (t.start)
        begin
            r_nxt.cnt  = t.load;
            r_nxt.busy = 1'b1;
        end
        else if (r.busy)
        begin
            if (r.cnt <= 1)
            begin
                r_nxt.busy = 1'b0;
                r_nxt.done = 1'b1;
                r_nxt.cnt  = '0;
            end
            else
                r_nxt.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            r <= '0;
        else
            r <= r_nxt;
    end

    assign t.busy = r.busy;
    assign t.done = r.done;
endmodule : frt_timer

// ===== design/fault_reaction_timing.sv
module fault_reaction_timing #(
    parameter int unsigned VMTO_SHORT_CYC = frt_pkg::VMTO_SHORT_CYC,
    parameter int unsigned VMTO_LONG_CYC  = frt_pkg::VMTO_LONG_CYC
) (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       class_a_event,
    input  wire logic       class_b_event,
    input  wire logic       desat_sense,
    input  wire logic       desat_blank_done,
    input  wire logic       overcurrent_sense,
    input  wire logic       oc_blank_done,
    input  wire logic       op_state_two,
    input  wire logic       verification_state,
    input  wire logic       verify_timeout_select,
    input  wire logic       gate_feedback,
    input  wire logic       life_sign_cond,
    input  wire logic       hard_transition,
    input  wire logic       osm_ok,
    input  wire logic       pwm_cmd,
    input  wire logic       fault_clear,
    input  wire logic [3:0] shoot_through_delay_field,
    output logic            fault_notify_class_a_n,
    output logic            fault_notify_class_b_n,
    output logic            turn_off_active,
    output logic            gate_drive,
    output logic            verify_timeout,
    output logic            gate_mon_timeout,
    output logic            life_sign_error,
    output logic            osm_inhibit,
    output logic            osm_fault
);
    localparam int C_CLA_MAX    = frt_pkg::OFF_CLA_MAX_CYC;
    localparam int C_CLB_MAX    = frt_pkg::OFF_CLB_MAX_CYC;
    localparam int C_DESAT_MAX  = frt_pkg::OFF_DESAT_MAX_CYC;
    localparam int C_OC_MAX     = frt_pkg::OFF_OC_MAX_CYC;
    localparam int C_NOTIFY_MAX = frt_pkg::NOTIFY_MAX_CYC;
    localparam int C_DEAD_MIN   = frt_pkg::DEAD_MIN_CYC;
    localparam int C_DEAD_MAX   = frt_pkg::DEAD_MAX_CYC;
    localparam int C_LS_CYC     = frt_pkg::LS_CYC;
    localparam int C_GATE_ON_MAX = frt_pkg::DEAD_MAX_CYC + 4;

    typedef struct packed {
        logic       a_prev;
        logic       b_prev;
        logic       op2_prev;
        logic       ver_prev;
        logic       life_prev;
        logic       hard_prev;
        logic       pwm_prev;
        logic       drive_prev;
        logic       notify_a_n;
        logic       notify_b_n;
        logic       turn_off;
        logic       drive;
        logic       vto;
        logic       gto;
        logic       ls_err;
        logic       osm_inh;
        logic       osm_flt;
        logic [7:0] pwm_hi_cnt;
        logic [9:0] life_hi_cnt;
    } frt_st_t;

    frt_st_t r;
    frt_st_t r_nxt;

    logic [frt_pkg::IN_W-1:0] pins;
    logic [frt_pkg::IN_W-1:0] s;
    logic                     a_rise;
    logic                     b_rise;
    logic                     ver_enter;
    logic                     life_rise;
    logic                     hard_rise;
    logic                     pwm_rise;
    logic                     drive_chg;
    logic                     off_trig;
    logic [frt_pkg::STP_W-1:0] stp;

    frt_tmr_if t_na ();
    frt_tmr_if t_nb ();
    frt_tmr_if t_vm ();
    frt_tmr_if t_gm ();
    frt_tmr_if t_ls ();
    frt_tmr_if t_os ();
    frt_tmr_if t_dt ();

    // every pin except mclk and srst passes two flip-flops first
    assign pins = {shoot_through_delay_field, fault_clear, pwm_cmd, osm_ok, hard_transition,
                   life_sign_cond, gate_feedback, verify_timeout_select, verification_state,
                   op_state_two, oc_blank_done, overcurrent_sense, desat_blank_done,
                   desat_sense, class_b_event, class_a_event};

    frt_sync #(.W(frt_pkg::IN_W)) u_sync (
        .mclk (mclk),
        .srst (srst),
        .d    (pins),
        .q    (s)
    );

    // trigger edges on the synchronised levels
    assign a_rise    = s[frt_pkg::IN_CLA] & ~r.a_prev;
    assign b_rise    = s[frt_pkg::IN_CLB] & ~r.b_prev;
    assign ver_enter = s[frt_pkg::IN_VER] & ~r.ver_prev & r.op2_prev;
    assign life_rise = s[frt_pkg::IN_LIFE] & ~r.life_prev;
    assign hard_rise = s[frt_pkg::IN_HARD] & ~r.hard_prev;
    assign pwm_rise  = s[frt_pkg::IN_PWM] & ~r.pwm_prev;
    assign drive_chg = r.drive ^ r.drive_prev;
    assign stp       = s[frt_pkg::IN_STP +: frt_pkg::STP_W];

    // turn-off sources, blanking gates the analog monitors
    assign off_trig = s[frt_pkg::IN_CLA]
                    | s[frt_pkg::IN_CLB]
                    | (s[frt_pkg::IN_DESAT] & s[frt_pkg::IN_DSBLK])
                    | (s[frt_pkg::IN_OC] & s[frt_pkg::IN_OCBLK]);

    // timer triggers and reload values
    assign t_na.start = a_rise;
    assign t_na.load  = frt_pkg::TMR_W'(frt_pkg::NOTIFY_CYC);
    assign t_nb.start = b_rise;
    assign t_nb.load  = frt_pkg::TMR_W'(frt_pkg::NOTIFY_CYC);
    assign t_vm.start = ver_enter;
    assign t_vm.load  = s[frt_pkg::IN_VSEL] ? frt_pkg::TMR_W'(VMTO_LONG_CYC)
                                            : frt_pkg::TMR_W'(VMTO_SHORT_CYC);
    assign t_gm.start = drive_chg;
    assign t_gm.load  = frt_pkg::TMR_W'(frt_pkg::GMTO_CYC);
    assign t_ls.start = life_rise;
    assign t_ls.load  = frt_pkg::TMR_W'(frt_pkg::LS_CYC);
    assign t_os.start = hard_rise;
    assign t_os.load  = frt_pkg::TMR_W'(frt_pkg::OSM_CYC);
    assign t_dt.start = pwm_rise;
    assign t_dt.load  = frt_pkg::TMR_W'((int'(stp) + 1) * frt_pkg::DEAD_STEP_CYC);

    frt_timer u_t_na (.mclk(mclk), .srst(srst), .t(t_na));
    frt_timer u_t_nb (.mclk(mclk), .srst(srst), .t(t_nb));
    frt_timer u_t_vm (.mclk(mclk), .srst(srst), .t(t_vm));
    frt_timer u_t_gm (.mclk(mclk), .srst(srst), .t(t_gm));
    frt_timer u_t_ls (.mclk(mclk), .srst(srst), .t(t_ls));
    frt_timer u_t_os (.mclk(mclk), .srst(srst), .t(t_os));
    frt_timer u_t_dt (.mclk(mclk), .srst(srst), .t(t_dt));

    // next state: flags set by hardware win over a clear in the same cycle
    always_comb
    begin
        r_nxt            = r;
        r_nxt.a_prev     = s[frt_pkg::IN_CLA];
        r_nxt.b_prev     = s[frt_pkg::IN_CLB];
        r_nxt.op2_prev   = s[frt_pkg::IN_OP2];
        r_nxt.ver_prev   = s[frt_pkg::IN_VER];
        r_nxt.life_prev  = s[frt_pkg::IN_LIFE];
        r_nxt.hard_prev  = s[frt_pkg::IN_HARD];
        r_nxt.pwm_prev   = s[frt_pkg::IN_PWM];
        r_nxt.drive_prev = r.drive;

        // fault notification, released only by fault clear
        if (t_na.done)
            r_nxt.notify_a_n = 1'b0;
        else if (s[frt_pkg::IN_CLR])
            r_nxt.notify_a_n = 1'b1;
        if (t_nb.done)
            r_nxt.notify_b_n = 1'b0;
        else if (s[frt_pkg::IN_CLR])
            r_nxt.notify_b_n = 1'b1;

        // turn-off sequence latch
        if (off_trig)
            r_nxt.turn_off = 1'b1;
        else if (s[frt_pkg::IN_CLR])
            r_nxt.turn_off = 1'b0;

        // gate command: immediate off, delayed on after the dead time
        if (r.turn_off || off_trig || !s[frt_pkg::IN_PWM])
            r_nxt.drive = 1'b0;
        else if (t_dt.done)
            r_nxt.drive = 1'b1;

        // verification mode timeout, dropped on leaving verification
        if (t_vm.done && s[frt_pkg::IN_VER])
            r_nxt.vto = 1'b1;
        else if (!s[frt_pkg::IN_VER])
            r_nxt.vto = 1'b0;

        // gate monitor compares feedback with own drive at timeout
        if (t_gm.done && (s[frt_pkg::IN_GFB] != r.drive))
            r_nxt.gto = 1'b1;
        else if (s[frt_pkg::IN_GFB] == r.drive)
            r_nxt.gto = 1'b0;

        // life sign error once condition persisted through the timer
        if (t_ls.done && s[frt_pkg::IN_LIFE])
            r_nxt.ls_err = 1'b1;
        else if (!s[frt_pkg::IN_LIFE])
            r_nxt.ls_err = 1'b0;

        // output stage monitor: blind while inhibited, judged at its end
        r_nxt.osm_inh = t_os.busy;
        if (t_os.done && !s[frt_pkg::IN_OSMOK])
            r_nxt.osm_flt = 1'b1;
        else if (s[frt_pkg::IN_CLR])
            r_nxt.osm_flt = 1'b0;

        // observation counters of consecutive high cycles, saturating
        if (!s[frt_pkg::IN_PWM])
            r_nxt.pwm_hi_cnt = '0;
        else if (r.pwm_hi_cnt != 8'hff)
            r_nxt.pwm_hi_cnt = r.pwm_hi_cnt + 8'h01;
        if (!s[frt_pkg::IN_LIFE])
            r_nxt.life_hi_cnt = '0;
        else if (r.life_hi_cnt != 10'h3ff)
            r_nxt.life_hi_cnt = r.life_hi_cnt + 10'h001;
    end

    // state register with reset values
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            r            <= '0;
            r.notify_a_n <= 1'b1;
            r.notify_b_n <= 1'b1;
        end
        else
            r <= r_nxt;
    end

    // outputs straight from the state register
    assign fault_notify_class_a_n = r.notify_a_n;
    assign fault_notify_class_b_n = r.notify_b_n;
    assign turn_off_active        = r.turn_off;
    assign gate_drive             = r.drive;
    assign verify_timeout         = r.vto;
    assign gate_mon_timeout       = r.gto;
    assign life_sign_error        = r.ls_err;
    assign osm_inhibit            = r.osm_inh;
    assign osm_fault              = r.osm_flt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // latency and interval checks
    a_cla_turn_off: assert property ($rose(s[frt_pkg::IN_CLA]) |-> ##[1:C_CLA_MAX] r.turn_off)
        else $error("class A turn-off too late");
    a_clb_turn_off: assert property ($rose(s[frt_pkg::IN_CLB]) |-> ##[1:C_CLB_MAX] r.turn_off)
        else $error("class B turn-off too late");
    a_desat_turn_off: assert property ((s[frt_pkg::IN_DESAT] && s[frt_pkg::IN_DSBLK])
        |-> ##[1:C_DESAT_MAX] r.turn_off)
        else $error("desat turn-off too late");
    a_oc_turn_off: assert property ((s[frt_pkg::IN_OC] && s[frt_pkg::IN_OCBLK])
        |-> ##[1:C_OC_MAX] r.turn_off)
        else $error("overcurrent turn-off too late");
    a_notify_a_low: assert property ($rose(s[frt_pkg::IN_CLA]) |-> ##[1:C_NOTIFY_MAX] !r.notify_a_n)
        else $error("class A notify too late");
    a_notify_b_low: assert property ($rose(s[frt_pkg::IN_CLB]) |-> ##[1:C_NOTIFY_MAX] !r.notify_b_n)
        else $error("class B notify too late");
    a_osm_inhibit_start: assert property (hard_rise |-> ##2 r.osm_inh)
        else $error("osm inhibit not raised");
    a_dead_time_win: assert property ((stp == frt_pkg::STP_DEFAULT) && $rose(r.drive)
        |-> (r.pwm_hi_cnt >= C_DEAD_MIN) && (r.pwm_hi_cnt <= C_DEAD_MAX + 2))
        else $error("dead time out of window");
    a_off_kills_gate: assert property (r.turn_off |=> !r.drive)
        else $error("gate driven during turn-off");
    a_life_err_wait: assert property ($rose(r.ls_err) |-> r.life_hi_cnt >= C_LS_CYC)
        else $error("life sign error too early");

    // sticky flags, refusals and the conditions behind each flag except gate_mon_timeout
    a_gate_on_clean: assert property ($rose(r.drive) |-> !r.turn_off)
        else $error("gate switched on during turn-off");
    a_drive_needs_pwm: assert property (!s[frt_pkg::IN_PWM] |=> !r.drive)
        else $error("gate driven without command");
    a_clear_off: assert property ((s[frt_pkg::IN_CLR] && !off_trig) |=> !r.turn_off)
        else $error("turn-off not released by clear");
    a_notify_a_sticky: assert property ((!r.notify_a_n && !s[frt_pkg::IN_CLR])
        |=> !r.notify_a_n)
        else $error("class A notify released without clear");
    a_notify_b_sticky: assert property ((!r.notify_b_n && !s[frt_pkg::IN_CLR])
        |=> !r.notify_b_n)
        else $error("class B notify released without clear");
    a_vto_in_ver: assert property (r.vto |-> $past(s[frt_pkg::IN_VER]))
        else $error("verify timeout outside verification");
    a_ls_needs_cond: assert property (!s[frt_pkg::IN_LIFE] |=> !r.ls_err)
        else $error("life sign error without condition");
    a_osm_flt_at_end: assert property ($rose(r.osm_flt)
        |-> $past(t_os.done))
        else $error("osm fault outside inhibit end");

    // main scenarios reached
    c_class_a_fault: cover property ($rose(s[frt_pkg::IN_CLA]) ##[1:C_NOTIFY_MAX] $fell(r.notify_a_n));
    c_gate_on: cover property (pwm_rise ##[1:C_GATE_ON_MAX] $rose(r.drive));
    c_verify_to: cover property ($rose(r.vto));
    c_gate_mon_to: cover property ($rose(r.gto));
    c_osm_window: cover property ($rose(r.osm_inh) ##[1:600] $fell(r.osm_inh));
endmodule : fault_reaction_timing

// ===== tb/frt_host_model.sv
module frt_host_model (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic fault_notify_class_a_n,
    input  wire logic fault_notify_class_b_n,
    output int        a_cnt,
    output int        b_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic a_q;
    logic b_q;

    // host counts each falling edge of a notify pin as one alert
    always @(posedge mclk)
    begin
        a_q <= fault_notify_class_a_n;
        b_q <= fault_notify_class_b_n;
        if (srst)
        begin
            a_cnt <= 0;
            b_cnt <= 0;
        end
        else
        begin
            if (a_q === 1'b1 && fault_notify_class_a_n === 1'b0)
                a_cnt <= a_cnt + 1;
            if (b_q === 1'b1 && fault_notify_class_b_n === 1'b0)
                b_cnt <= b_cnt + 1;
        end
    end
endmodule : frt_host_model

// ===== tb/fault_reaction_timing_test.sv
module fault_reaction_timing_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int VS    = 200;
    localparam int VL    = 800;
    localparam int LIMIT = 40000;

    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic       ev_a, ev_b, desat, dblk, oc, oc_blk, op2, ver, vsel;
    logic       gfb, life, hard, ok, pwm, clr;
    logic [3:0] stp;
    wire  [8:0] outs;
    int         n_fail;
    int         cmp_count;
    int         cyc;
    int         a_cnt;
    int         b_cnt;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    fault_reaction_timing #(.VMTO_SHORT_CYC(VS), .VMTO_LONG_CYC(VL)) u_dut (
        .mclk(mclk), .srst(srst), .class_a_event(ev_a), .class_b_event(ev_b),
        .desat_sense(desat), .desat_blank_done(dblk), .overcurrent_sense(oc),
        .oc_blank_done(oc_blk), .op_state_two(op2), .verification_state(ver),
        .verify_timeout_select(vsel), .gate_feedback(gfb), .life_sign_cond(life),
        .hard_transition(hard), .osm_ok(ok), .pwm_cmd(pwm), .fault_clear(clr),
        .shoot_through_delay_field(stp),
        .fault_notify_class_a_n(outs[0]), .fault_notify_class_b_n(outs[1]),
        .turn_off_active(outs[2]), .gate_drive(outs[3]), .verify_timeout(outs[4]),
        .gate_mon_timeout(outs[5]), .life_sign_error(outs[6]), .osm_inhibit(outs[7]),
        .osm_fault(outs[8])
    );

    frt_host_model u_host (
        .mclk(mclk), .srst(srst), .fault_notify_class_a_n(outs[0]),
        .fault_notify_class_b_n(outs[1]), .a_cnt(a_cnt), .b_cnt(b_cnt)
    );

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // hang guard
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == LIMIT)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h..%h", $time, got, lo, hi);
        end
    endtask : chk

    // counts falling edges until output k shows v, gives up past hi
    task automatic measure(input int k, input logic v, input int hi, output int n);
        n = 0;
        while (outs[k] !== v && n < hi + 10)
        begin
            @(negedge mclk);
            n++;
        end
    endtask : measure

    task automatic idle(input int c);
        repeat (c) @(negedge mclk);
    endtask : idle

    task automatic clear_all;
        int n;
        ev_a = 0;
        ev_b = 0;
        desat = 0;
        oc = 0;
        clr = 1;
        measure(2, 1'b0, 8, n);
        chk(n, 0, 8);
        idle(2);
        chk(outs[1:0], 2'h3, 2'h3);
        clr = 0;
        idle(3);
    endtask : clear_all

    // one class event: fast turn-off, slower notify on its own pin only
    task automatic t_class(input int sel);
        int n1;
        int n2;
        if (sel == 1)
            ev_b = 1;
        else
            ev_a = 1;
        pwm = 1;
        measure(2, 1'b1, frt_pkg::OFF_CLA_MAX_CYC, n1);
        chk(n1, 1, frt_pkg::OFF_CLA_MAX_CYC);
        chk(outs[3], 0, 0);
        measure(sel, 1'b0, frt_pkg::NOTIFY_MAX_CYC, n2);
        chk(n1 + n2, frt_pkg::NOTIFY_CYC, frt_pkg::NOTIFY_MAX_CYC);
        chk(outs[3], 0, 0);
        chk(outs[1 - sel], 1, 1);
        pwm = 0;
        idle(2);
        chk(a_cnt + b_cnt, sel + 1, sel + 1);
        clear_all();
    endtask : t_class

    // desaturation ignored during blanking, acted on after
    task automatic t_desat;
        int n;
        desat = 1;
        idle(20);
        chk(outs[2], 0, 0);
        dblk = 1;
        measure(2, 1'b1, frt_pkg::OFF_DESAT_MAX_CYC, n);
        chk(n, 1, frt_pkg::OFF_DESAT_MAX_CYC);
        clear_all();
        dblk = 0;
    endtask : t_desat

    task automatic t_oc;
        int n;
        oc_blk = 1;
        oc = 1;
        measure(2, 1'b1, frt_pkg::OFF_OC_MAX_CYC, n);
        chk(n, 1, frt_pkg::OFF_OC_MAX_CYC);
        clear_all();
        oc_blk = 0;
    endtask : t_oc

    // dead time before gate on, then gate monitor with feedback held low
    task automatic t_dead(input logic [3:0] field, input int lo, input int hi);
        int n;
        stp = field;
        gfb = 0;
        pwm = 1;
        measure(3, 1'b1, hi, n);
        chk(n, lo, hi);
        measure(5, 1'b1, frt_pkg::GMTO_CYC + 4, n);
        chk(n, frt_pkg::GMTO_CYC, frt_pkg::GMTO_CYC + 4);
        gfb = 1;
        idle(4);
        chk(outs[5], 0, 0);
        pwm = 0;
        measure(3, 1'b0, 4, n);
        chk(n, 1, 4);
        gfb = 0;
        idle(4);
        chk(outs[5], 0, 0);
    endtask : t_dead

    task automatic t_verify(input logic sel, input int cn);
        int n;
        op2 = 1;
        vsel = sel;
        idle(4);
        ver = 1;
        measure(4, 1'b1, cn + 6, n);
        chk(n, cn, cn + 6);
        ver = 0;
        op2 = 0;
        idle(4);
        chk(outs[4], 0, 0);
    endtask : t_verify

    // entry not from state two starts no timeout
    task automatic t_verify_bare;
        ver = 1;
        idle(VS + 20);
        chk(outs[4], 0, 0);
        ver = 0;
        idle(4);
    endtask : t_verify_bare

    // interrupted condition restarts the life sign count
    task automatic t_life;
        int n;
        life = 1;
        idle(300);
        life = 0;
        idle(4);
        chk(outs[6], 0, 0);
        life = 1;
        measure(6, 1'b1, frt_pkg::LS_CYC + 6, n);
        chk(n, frt_pkg::LS_CYC, frt_pkg::LS_CYC + 6);
        life = 0;
        idle(4);
        chk(outs[6], 0, 0);
    endtask : t_life

    task automatic t_osm;
        int n;
        hard = 1;
        measure(7, 1'b1, 6, n);
        chk(n, 1, 6);
        hard = 0;
        measure(7, 1'b0, frt_pkg::OSM_CYC + 2, n);
        chk(n, frt_pkg::OSM_CYC - 2, frt_pkg::OSM_CYC + 1);
        chk(outs[8], 0, 0);
        hard = 1;
        idle(4);
        hard = 0;
        idle(200);
        ok = 0;
        hard = 1;
        idle(4);
        hard = 0;
        chk(outs[8], 0, 0);
        measure(7, 1'b0, frt_pkg::OSM_CYC + 2, n);
        chk(n, frt_pkg::OSM_CYC - 6, frt_pkg::OSM_CYC + 1);
        idle(2);
        chk(outs[8], 1, 1);
        ok = 1;
        clear_all();
        chk(outs[8], 0, 0);
    endtask : t_osm

    initial
    begin
        {ev_a, ev_b, desat, dblk, oc, oc_blk, op2, ver, vsel} = '0;
        {gfb, life, hard, pwm, clr} = '0;
        ok = 1;
        stp = frt_pkg::STP_DEFAULT;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        idle(6);
        srst = 0;
        chk(outs, 9'h003, 9'h003);
        idle(4);
        t_class(0);
        t_class(1);
        t_desat();
        t_oc();
        t_dead(frt_pkg::STP_DEFAULT, frt_pkg::DEAD_MIN_CYC, frt_pkg::DEAD_MAX_CYC);
        t_dead(4'h0, 25, 31);
        t_verify(1'b0, VS);
        t_verify(1'b1, VL);
        t_verify_bare();
        t_life();
        t_osm();
        report_and_stop();
    end
endmodule : fault_reaction_timing_test
